// File: bmm_map.svh
// Constants of the banked memory address map: offsets, field positions, reset values, vectors.
// Assumes inclusion by bare name from the package and the design modules.
// Function
// [RL1] Program counter is 13 bits; only the low 2k words exist.
// [RL2] Fetches above the implemented space wrap into the low 2k words.
// [RL3] Reset starts at 0000h; a taken interrupt vectors to 0004h.
// [RL4] Four data banks; special function registers fill the low 32 of each.
// [RL5] RAM at 20h-7Fh in bank 0 and A0h-BFh in bank 1.
// [RL6] Top sixteen of banks 1, 2, 3 map onto bank 0 70h-7Fh.
// [RL7] Reads of unimplemented data locations return zero.
// [RL8] Direct address is seven opcode bits plus two bank-select bits.
// [RL9] Bank bits select the bank in binary, high flag most significant.
// [RL10] Indirect address is pointer's eight bits plus the indirect bank bit.
// [RL11] Each bank holds 128 bytes, reachable directly or indirectly.
`ifndef BMM_MAP_SVH
`define BMM_MAP_SVH

// ==========================================================================
// Program memory
`define BMM_PC_W 13
`define BMM_IMPL_AW 11
`define BMM_RESET_VEC 13'h0000
`define BMM_IRQ_VEC 13'h0004

// ==========================================================================
// Data memory
`define BMM_DADDR_W 9
`define BMM_BANK_OFS_W 7
`define BMM_SFR_END 7'h1F
`define BMM_GPR_LO 7'h20
`define BMM_B1_GPR_HI 7'h3F
`define BMM_COMMON_LO 7'h70
`define BMM_B1_RAM_SHIFT 7'h40
`define BMM_RAM_DEPTH 128

// ==========================================================================
// Register offsets (byte addresses) and fields
`define BMM_APB_AW 12
`define BMM_OFF_BANK 12'h000
`define BMM_OFF_PTR 12'h004
`define BMM_OFF_PC 12'h008
`define BMM_OFF_LAST 12'h00C
`define BMM_BANK_LOW_BIT 0
`define BMM_BANK_HIGH_BIT 1
`define BMM_IND_BANK_BIT 2
`define BMM_LAST_REGION_LSB 12
`define BMM_BANK_RESET 3'h0
`define BMM_PTR_RESET 8'h00

`endif

// File: bmm_pkg.sv
// Types shared by the banked memory address map modules.
// Assumes bmm_map.svh is reachable on the include path.
`include "bmm_map.svh"

package bmm_pkg;

  typedef enum logic [1:0] {
    BMM_REG_SFR,
    BMM_REG_GPR,
    BMM_REG_UNIMP
  } bmm_region_t;

  typedef struct packed {
    bmm_region_t region;
    logic [`BMM_BANK_OFS_W-1:0] ram_idx;
  } bmm_decode_t;

endpackage : bmm_pkg

// File: bmm_dec_if.sv
// Carrier between the top module and the data address decoder.
// Assumes one driver of the request side (top) and one of the answer side (decoder).
`timescale 1ns/1ns
`include "bmm_map.svh"

interface bmm_dec_if;
  import bmm_pkg::*;

  logic indirect;
  logic [`BMM_BANK_OFS_W-1:0] opcode_addr;
  logic bank_select_low;
  logic bank_select_high;
  logic indirect_bank_bit;
  logic [7:0] indirect_pointer;
  logic [`BMM_DADDR_W-1:0] eff_addr;
  bmm_decode_t decode;

  modport requester (
    output indirect, opcode_addr, bank_select_low, bank_select_high,
    output indirect_bank_bit, indirect_pointer,
    input eff_addr, decode
  );

  modport decoder (
    input indirect, opcode_addr, bank_select_low, bank_select_high,
    input indirect_bank_bit, indirect_pointer,
    output eff_addr, decode
  );

endinterface : bmm_dec_if

// File: bmm_decode.sv
// Data-memory address former and decoder, purely combinational.
// Assumes the requester holds its fields stable for the cycle of the access.
`timescale 1ns/1ns
`include "bmm_map.svh"

module bmm_decode
  import bmm_pkg::*;
(
  // Decode carrier
  bmm_dec_if.decoder dec
);

  // ==========================================================================
  // Region and RAM index of a nine-bit data address
  function automatic bmm_decode_t classify(input logic [`BMM_DADDR_W-1:0] a);
    bmm_decode_t d;
    logic [1:0] bank;
    logic [`BMM_BANK_OFS_W-1:0] ofs;
    bank = a[`BMM_DADDR_W-1:`BMM_BANK_OFS_W]; // RL9
    ofs = a[`BMM_BANK_OFS_W-1:0]; // RL11
    d.region = BMM_REG_UNIMP;
    d.ram_idx = '0;
    if (ofs <= `BMM_SFR_END) begin
      d.region = BMM_REG_SFR; // RL4
    end else if (bank == 2'b00) begin
      d.region = BMM_REG_GPR; // RL5
      d.ram_idx = ofs - `BMM_GPR_LO;
    end else if (ofs >= `BMM_COMMON_LO) begin
      // Shared bytes live once, in the bank 0 part of the array.
      d.region = BMM_REG_GPR; // RL6
      d.ram_idx = ofs - `BMM_GPR_LO;
    end else if (bank == 2'b01 && ofs <= `BMM_B1_GPR_HI) begin
      d.region = BMM_REG_GPR; // RL5
      d.ram_idx = ofs + `BMM_B1_RAM_SHIFT;
    end
    return d;
  endfunction : classify

  // ==========================================================================
  // Effective address
  always_comb begin
    if (dec.indirect) begin
      dec.eff_addr = {dec.indirect_bank_bit, dec.indirect_pointer}; // RL10
    end else begin
      dec.eff_addr = {dec.bank_select_high, dec.bank_select_low, dec.opcode_addr}; // RL8
    end
  end

  assign dec.decode = classify(dec.eff_addr);

endmodule : bmm_decode

// File: bmm_top.sv
// Banked memory address map: program counter, data RAM with banked decode, APB registers.
// Assumes the core datapath drives its strobes synchronously to sys_clk_in, one access a cycle.
`timescale 1ns/1ns
`include "bmm_map.svh"

module bmm_top
  import bmm_pkg::*;
#(
  parameter int RAM_DEPTH = `BMM_RAM_DEPTH
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [`BMM_APB_AW-1:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [3:0] pstrb_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Program fetch
  input wire logic pc_inc_in,
  input wire logic pc_load_in,
  input wire logic [`BMM_PC_W-1:0] pc_load_value_in,
  input wire logic irq_take_in,
  output logic [`BMM_PC_W-1:0] pc_out,
  output logic [`BMM_IMPL_AW-1:0] fetch_addr_out,
  // Data access
  input wire logic dm_req_in,
  input wire logic dm_write_in,
  input wire logic dm_indirect_in,
  input wire logic [`BMM_BANK_OFS_W-1:0] dm_opcode_addr_in,
  input wire logic [7:0] dm_wdata_in,
  output logic [7:0] dm_rdata_out,
  output logic dm_rvalid_out,
  // Special function register side
  output logic sfr_sel_out,
  output logic sfr_we_out,
  output logic [`BMM_DADDR_W-1:0] sfr_addr_out,
  input wire logic [7:0] sfr_rdata_in
);

  // ==========================================================================
  // Program counter
  logic [`BMM_PC_W-1:0] pc;
  logic [`BMM_PC_W-1:0] next_pc;

  always_comb begin
    next_pc = pc;
    if (irq_take_in) begin
      next_pc = `BMM_IRQ_VEC; // RL3
    end else if (pc_load_in) begin
      next_pc = pc_load_value_in;
    end else if (pc_inc_in) begin
      // The full 13-bit count rolls over naturally.
      next_pc = pc + `BMM_PC_W'(1); // RL1
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      pc <= `BMM_RESET_VEC; // RL3
    end else begin
      pc <= next_pc;
    end
  end

  assign pc_out = pc;
  // Dropping the upper bits is the wrap into the implemented 2k words.
  assign fetch_addr_out = pc[`BMM_IMPL_AW-1:0]; // RL2

  // ==========================================================================
  // Bank and pointer registers, written over APB
  logic bank_select_low;
  logic bank_select_high;
  logic indirect_bank_bit;
  logic [7:0] indirect_pointer;
  logic next_bank_select_low;
  logic next_bank_select_high;
  logic next_indirect_bank_bit;
  logic [7:0] next_indirect_pointer;
  logic apb_access;
  logic apb_setup;
  logic apb_wr;
  logic addr_mapped;

  assign apb_setup = psel_in && !penable_in;
  assign apb_access = psel_in && penable_in;
  assign apb_wr = apb_access && pwrite_in && addr_mapped && pstrb_in[0];

  always_comb begin
    unique case (paddr_in)
      `BMM_OFF_BANK, `BMM_OFF_PTR, `BMM_OFF_PC, `BMM_OFF_LAST: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  end

  always_comb begin
    next_bank_select_low = bank_select_low;
    next_bank_select_high = bank_select_high;
    next_indirect_bank_bit = indirect_bank_bit;
    next_indirect_pointer = indirect_pointer;
    if (apb_wr && paddr_in == `BMM_OFF_BANK) begin
      next_bank_select_low = pwdata_in[`BMM_BANK_LOW_BIT];
      next_bank_select_high = pwdata_in[`BMM_BANK_HIGH_BIT];
      next_indirect_bank_bit = pwdata_in[`BMM_IND_BANK_BIT];
    end
    if (apb_wr && paddr_in == `BMM_OFF_PTR) begin
      next_indirect_pointer = pwdata_in[7:0];
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      {indirect_bank_bit, bank_select_high, bank_select_low} <= `BMM_BANK_RESET;
      indirect_pointer <= `BMM_PTR_RESET;
    end else begin
      bank_select_low <= next_bank_select_low;
      bank_select_high <= next_bank_select_high;
      indirect_bank_bit <= next_indirect_bank_bit;
      indirect_pointer <= next_indirect_pointer;
    end
  end

  // ==========================================================================
  // Address decode
  bmm_dec_if dec_bus();

  assign dec_bus.indirect = dm_indirect_in;
  assign dec_bus.opcode_addr = dm_opcode_addr_in;
  assign dec_bus.bank_select_low = bank_select_low;
  assign dec_bus.bank_select_high = bank_select_high;
  assign dec_bus.indirect_bank_bit = indirect_bank_bit;
  assign dec_bus.indirect_pointer = indirect_pointer;

  bmm_decode u_decode (
    .dec(dec_bus.decoder)
  );

  // ==========================================================================
  // Data RAM and read path
  logic [7:0] ram [RAM_DEPTH];
  logic ram_we;
  logic [7:0] dm_rdata;
  logic dm_rvalid;
  logic [`BMM_DADDR_W-1:0] last_addr;
  bmm_region_t last_region;
  logic [7:0] next_dm_rdata;
  logic next_dm_rvalid;
  logic [`BMM_DADDR_W-1:0] next_last_addr;
  bmm_region_t next_last_region;

  assign ram_we = dm_req_in && dm_write_in && dec_bus.decode.region == BMM_REG_GPR;
  assign sfr_sel_out = dm_req_in && dec_bus.decode.region == BMM_REG_SFR;
  assign sfr_we_out = sfr_sel_out && dm_write_in;
  assign sfr_addr_out = dec_bus.eff_addr;

  // Writes to unimplemented locations fall on the floor by design.
  always_ff @(posedge sys_clk_in) begin
    if (ram_we) begin
      ram[dec_bus.decode.ram_idx] <= dm_wdata_in; // RL11
    end
  end

  always_comb begin
    next_dm_rdata = dm_rdata;
    next_dm_rvalid = 1'b0;
    next_last_addr = last_addr;
    next_last_region = last_region;
    if (dm_req_in) begin
      next_last_addr = dec_bus.eff_addr;
      next_last_region = dec_bus.decode.region;
      if (!dm_write_in) begin
        next_dm_rvalid = 1'b1;
        unique case (dec_bus.decode.region)
          BMM_REG_SFR: next_dm_rdata = sfr_rdata_in;
          BMM_REG_GPR: next_dm_rdata = ram[dec_bus.decode.ram_idx];
          default: next_dm_rdata = 8'h00; // RL7
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      dm_rdata <= 8'h00;
      dm_rvalid <= 1'b0;
      last_addr <= '0;
      last_region <= BMM_REG_SFR;
    end else begin
      dm_rdata <= next_dm_rdata;
      dm_rvalid <= next_dm_rvalid;
      last_addr <= next_last_addr;
      last_region <= next_last_region;
    end
  end

  assign dm_rdata_out = dm_rdata;
  assign dm_rvalid_out = dm_rvalid;

  // ==========================================================================
  // APB read data, captured in the setup cycle so the answer is zero-wait
  logic [31:0] prdata;
  logic [31:0] next_prdata;

  always_comb begin
    next_prdata = prdata;
    if (apb_setup) begin
      unique case (paddr_in)
        `BMM_OFF_BANK: next_prdata = {29'h0000_0000, indirect_bank_bit,
                                      bank_select_high, bank_select_low};
        `BMM_OFF_PTR: next_prdata = {24'h00_0000, indirect_pointer};
        `BMM_OFF_PC: next_prdata = {19'h0_0000, pc};
        `BMM_OFF_LAST: next_prdata = {18'h0_0000, last_region, 3'h0, last_addr};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or posedge reset_in) begin
    if (reset_in) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end

  assign prdata_out = prdata;
  assign pready_out = apb_access;
  assign pslverr_out = apb_access && !addr_mapped;

endmodule : bmm_top

// File: bmm_props.sv
// Checker of the banked memory address map, bound into its top module.
// Assumes it sees only the top module's ports.
`timescale 1ns/1ns
`include "bmm_map.svh"

module bmm_checker #(
  parameter int RAM_DEPTH = 128
) (
  // Clock and reset
  input wire logic sys_clk_in,
  input wire logic reset_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [`BMM_APB_AW-1:0] paddr_in,
  input wire logic pslverr_out,
  // Program fetch
  input wire logic pc_inc_in,
  input wire logic pc_load_in,
  input wire logic irq_take_in,
  input wire logic [`BMM_PC_W-1:0] pc_out,
  input wire logic [`BMM_IMPL_AW-1:0] fetch_addr_out,
  // Data access
  input wire logic dm_req_in,
  input wire logic dm_write_in,
  input wire logic dm_indirect_in,
  input wire logic [`BMM_BANK_OFS_W-1:0] dm_opcode_addr_in,
  input wire logic [7:0] dm_rdata_out,
  input wire logic dm_rvalid_out,
  input wire logic sfr_sel_out,
  input wire logic sfr_we_out,
  input wire logic [`BMM_DADDR_W-1:0] sfr_addr_out,
  input wire logic [7:0] sfr_rdata_in
);
  logic [6:0] ofs;
  logic unimp;
  assign ofs = sfr_addr_out[6:0];
  // Bank 1 keeps RAM only below 40h; banks 2 and 3 only share the top sixteen.
  assign unimp = ofs >= 7'h20 && ofs < 7'h70 &&
    (sfr_addr_out[8] || (sfr_addr_out[7] && ofs >= 7'h40));

  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);
  sequence rd_req;
    dm_req_in && !dm_write_in;
  endsequence

  // ====
  // Assertions
  a_reset_start: assert property ($fell(reset_in) |-> pc_out == 13'h0000)
    else $error("pc not at reset vector");
  a_irq_vector: assert property (irq_take_in |=> pc_out == 13'h0004)
    else $error("pc not at interrupt vector");
  a_pc_step: assert property (pc_inc_in && !pc_load_in && !irq_take_in |=>
    pc_out == $past(pc_out) + 13'h0001) else $error("pc did not advance");
  a_fetch_wrap: assert property (fetch_addr_out == pc_out[10:0])
    else $error("fetch address not wrapped");
  a_sfr_select: assert property (dm_req_in |-> sfr_sel_out == (ofs <= 7'h1F))
    else $error("sfr select wrong");
  a_sfr_write: assert property (sfr_we_out == (dm_req_in && dm_write_in && ofs <= 7'h1F))
    else $error("sfr write strobe wrong");
  a_direct_addr: assert property (dm_req_in && !dm_indirect_in |->
    ofs == dm_opcode_addr_in) else $error("direct offset wrong");
  a_read_answer: assert property (rd_req |=> dm_rvalid_out)
    else $error("no read answer");
  a_unimp_zero: assert property (rd_req ##0 unimp |=> dm_rdata_out == 8'h00)
    else $error("unimplemented read not zero");
  a_sfr_pass: assert property (rd_req ##0 sfr_sel_out |=>
    dm_rdata_out == $past(sfr_rdata_in)) else $error("sfr data not passed");
  a_slv_error: assert property (psel_in && penable_in && paddr_in[11:4] != 8'h00 |->
    pslverr_out) else $error("unmapped access not refused");
endmodule : bmm_checker

bind bmm_top bmm_checker #(.RAM_DEPTH(RAM_DEPTH)) i_bmm_checker (.sys_clk_in, .reset_in,
  .psel_in, .penable_in, .paddr_in, .pslverr_out, .pc_inc_in, .pc_load_in, .irq_take_in,
  .pc_out, .fetch_addr_out, .dm_req_in, .dm_write_in, .dm_indirect_in, .dm_opcode_addr_in,
  .dm_rdata_out, .dm_rvalid_out, .sfr_sel_out, .sfr_we_out, .sfr_addr_out, .sfr_rdata_in);

// File: bmm_core_model.sv
// Behavioural model of the core datapath that drives fetch and data strobes.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/1ns

module bmm_core_model (
  // Clock and answers
  input wire logic sys_clk_in,
  input wire logic [7:0] dm_rdata_in,
  input wire logic dm_rvalid_in,
  // Strobes to the block
  output logic pc_inc_out = 1'b0,
  output logic pc_load_out = 1'b0,
  output logic [12:0] pc_load_value_out = 13'h0000,
  output logic irq_take_out = 1'b0,
  output logic dm_req_out = 1'b0,
  output logic dm_write_out = 1'b0,
  output logic dm_indirect_out = 1'b0,
  output logic [6:0] dm_opcode_addr_out = 7'h00,
  output logic [7:0] dm_wdata_out = 8'h00
);
  task automatic pc_op(input logic inc, input logic ld, input logic irq, input logic [12:0] v);
    @(posedge sys_clk_in);
    pc_inc_out <= inc;
    pc_load_out <= ld;
    irq_take_out <= irq;
    pc_load_value_out <= v;
    @(posedge sys_clk_in);
    pc_inc_out <= 1'b0;
    pc_load_out <= 1'b0;
    irq_take_out <= 1'b0;
    pc_load_value_out <= ~v;
  endtask : pc_op

  task automatic dm_access(input logic ind, input logic [6:0] ofs, input logic wr,
                           input logic [7:0] wd, output logic [7:0] rd);
    @(posedge sys_clk_in);
    dm_req_out <= 1'b1;
    dm_write_out <= wr;
    dm_indirect_out <= ind;
    dm_opcode_addr_out <= ofs;
    dm_wdata_out <= wd;
    @(posedge sys_clk_in);
    dm_req_out <= 1'b0;
    // The released address and write data lines flip, so a stale value can never pass for a fresh one.
    dm_opcode_addr_out <= ~ofs;
    dm_wdata_out <= ~wd;
    rd = 8'hxx;
    for (int n = 0; n < 4 && !wr; n++) begin
      @(negedge sys_clk_in);
      if (dm_rvalid_in === 1'b1) begin
        rd = dm_rdata_in;
        break;
      end
    end
  endtask : dm_access
endmodule : bmm_core_model

// File: banked_memory_address_map_bench.sv
// Self-checking bench of the banked memory address map.
// Assumes the design files, the checker and the core model are compiled first.
`timescale 1ns/1ns
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e); end end

module banked_memory_address_map_bench;
  import bmm_pkg::*;
  typedef struct packed {
    logic [2:0] bank;
    logic [7:0] ptr;
    logic ind;
    logic [6:0] ofs;
    logic wr;
    logic [7:0] wd;
    logic [7:0] exp;
  } bmm_row_t;
  logic sys_clk_in = 1'b0, reset_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0;
  logic pwrite_in = 1'b0, pready_out, pslverr_out, dm_rvalid_out, sfr_sel_out, sfr_we_out;
  logic pc_inc_in, pc_load_in, irq_take_in, dm_req_in, dm_write_in, dm_indirect_in;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0000_0000, prdata_out, rd;
  logic [3:0] pstrb_in = 4'hF;
  logic [12:0] pc_load_value_in, pc_out;
  logic [10:0] fetch_addr_out;
  logic [6:0] dm_opcode_addr_in;
  logic [7:0] dm_wdata_in, dm_rdata_out, sfr_rdata_in, rd8;
  logic [8:0] sfr_addr_out;
  logic err;
  int error_cnt = 0;
  int checks_done = 0;
  // Direct bank 0..3, then indirect with the indirect bank bit in bit 2; row 14 is a direct SFR write.
  bmm_row_t rows [16] = '{
    '{3'd0, 8'h00, 1'b0, 7'h25, 1'b1, 8'hAA, 8'h00},
    '{3'd0, 8'h00, 1'b0, 7'h25, 1'b0, 8'h00, 8'hAA},
    '{3'd1, 8'h00, 1'b0, 7'h25, 1'b1, 8'h11, 8'h00},
    '{3'd1, 8'h00, 1'b0, 7'h25, 1'b0, 8'h00, 8'h11},
    '{3'd0, 8'h00, 1'b0, 7'h25, 1'b0, 8'h00, 8'hAA},
    '{3'd2, 8'h00, 1'b0, 7'h7A, 1'b1, 8'h5C, 8'h00},
    '{3'd0, 8'h00, 1'b0, 7'h7A, 1'b0, 8'h00, 8'h5C},
    '{3'd3, 8'h00, 1'b0, 7'h7A, 1'b0, 8'h00, 8'h5C},
    '{3'd2, 8'h00, 1'b0, 7'h30, 1'b1, 8'h77, 8'h00},
    '{3'd2, 8'h00, 1'b0, 7'h30, 1'b0, 8'h00, 8'h00},
    '{3'd1, 8'h00, 1'b0, 7'h45, 1'b0, 8'h00, 8'h00},
    '{3'd3, 8'h00, 1'b0, 7'h05, 1'b0, 8'h00, 8'hB9},
    '{3'd0, 8'hA5, 1'b1, 7'h00, 1'b0, 8'h00, 8'h11},
    '{3'd4, 8'hFA, 1'b1, 7'h00, 1'b0, 8'h00, 8'h5C},
    '{3'd1, 8'h00, 1'b0, 7'h0A, 1'b1, 8'h42, 8'h00},
    '{3'd4, 8'h25, 1'b1, 7'h00, 1'b0, 8'h00, 8'h00}};

  assign sfr_rdata_in = sfr_addr_out[7:0] ^ 8'h3C;
  bmm_top i_bmm_top (.sys_clk_in, .reset_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .pstrb_in, .prdata_out, .pready_out, .pslverr_out, .pc_inc_in, .pc_load_in,
    .pc_load_value_in, .irq_take_in, .pc_out, .fetch_addr_out, .dm_req_in, .dm_write_in,
    .dm_indirect_in, .dm_opcode_addr_in, .dm_wdata_in, .dm_rdata_out, .dm_rvalid_out,
    .sfr_sel_out, .sfr_we_out, .sfr_addr_out, .sfr_rdata_in);
  bmm_core_model i_bmm_core_model (.sys_clk_in, .dm_rdata_in(dm_rdata_out),
    .dm_rvalid_in(dm_rvalid_out), .pc_inc_out(pc_inc_in), .pc_load_out(pc_load_in),
    .pc_load_value_out(pc_load_value_in), .irq_take_out(irq_take_in), .dm_req_out(dm_req_in),
    .dm_write_out(dm_write_in), .dm_indirect_out(dm_indirect_in),
    .dm_opcode_addr_out(dm_opcode_addr_in), .dm_wdata_out(dm_wdata_in));

  initial begin
    forever #5 sys_clk_in = ~sys_clk_in;
  end

  task automatic conclude;
    $display("checks %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : conclude

  // ====
  // APB master: request held until pready is seen high at a rising edge.
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge sys_clk_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge sys_clk_in);
    penable_in <= 1'b1;
    for (int n = 0; n <= 8; n++) begin
      @(posedge sys_clk_in);
      if (pready_out === 1'b1) break;
      if (n == 8) begin
        error_cnt++;
        conclude();
      end
    end
    q = prdata_out;
    e = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask : apb

  initial begin
    #200000;
    error_cnt++;
    conclude();
  end

  initial begin
    repeat (3) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    @(negedge sys_clk_in);
    `CHK(pc_out, 13'h0000)
    apb(1'b0, 12'h000, 32'h0000_0000, rd, err);
    `CHK(rd, 32'h0000_0000)
    $display("test reset done");
    for (int i = 0; i < 16; i++) begin
      apb(1'b1, 12'h000, {29'h0, rows[i].bank}, rd, err);
      apb(1'b1, 12'h004, {24'h0, rows[i].ptr}, rd, err);
      i_bmm_core_model.dm_access(rows[i].ind, rows[i].ofs, rows[i].wr, rows[i].wd, rd8);
      if (!rows[i].wr) `CHK(rd8, rows[i].exp)
    end
    apb(1'b0, 12'h00C, 32'h0000_0000, rd, err);
    `CHK(rd, 32'h0000_2125)
    apb(1'b0, 12'h004, 32'h0000_0000, rd, err);
    `CHK(rd, 32'h0000_0025)
    `CHK(err, 1'b0)
    apb(1'b0, 12'h000, 32'h0000_0000, rd, err);
    `CHK(rd, 32'h0000_0004)
    $display("test data map done");
    i_bmm_core_model.pc_op(1'b0, 1'b1, 1'b0, 13'h07FE);
    i_bmm_core_model.pc_op(1'b1, 1'b0, 1'b0, 13'h0000);
    i_bmm_core_model.pc_op(1'b1, 1'b0, 1'b0, 13'h0000);
    @(negedge sys_clk_in);
    `CHK(fetch_addr_out, 11'h000)
    i_bmm_core_model.pc_op(1'b0, 1'b1, 1'b0, 13'h1FFF);
    i_bmm_core_model.pc_op(1'b1, 1'b0, 1'b0, 13'h0000);
    @(negedge sys_clk_in);
    `CHK(pc_out, 13'h0000)
    i_bmm_core_model.pc_op(1'b1, 1'b1, 1'b1, 13'h0123);
    apb(1'b1, 12'h008, 32'h0000_0055, rd, err);
    apb(1'b0, 12'h008, 32'h0000_0000, rd, err);
    `CHK(rd, 32'h0000_0004)
    $display("test fetch done");
    apb(1'b0, 12'h010, 32'h0000_0000, rd, err);
    `CHK({err, rd}, {1'b1, 32'h0000_0000})
    // A write without lane 0 must leave the bank bits alone.
    pstrb_in <= 4'h0;
    apb(1'b1, 12'h000, 32'h0000_0003, rd, err);
    pstrb_in <= 4'hF;
    apb(1'b0, 12'h000, 32'h0000_0000, rd, err);
    `CHK(rd, 32'h0000_0004)
    $display("test refusal done");
    reset_in <= 1'b1;
    @(posedge sys_clk_in);
    reset_in <= 1'b0;
    @(negedge sys_clk_in);
    `CHK(pc_out, 13'h0000)
    apb(1'b0, 12'h000, 32'h0000_0000, rd, err);
    `CHK(rd, 32'h0000_0000)
    $display("test mid reset done");
    conclude();
  end
endmodule : banked_memory_address_map_bench
